// ==== scsc_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef SCSC_MAP_SVH
`define SCSC_MAP_SVH
`define SCSC_PSC_ADDR      16'hF000
`define SCSC_CCS_ADDR      16'hF009
`define SCSC_PSC_RESET     8'h01
`define SCSC_CCS_RESET     8'h00
`define SCSC_BIT_PIN_WAKE  0
`define SCSC_BIT_WDT_WAKE  1
`define SCSC_BIT_SLEEP     2
`define SCSC_BIT_FAST_KEEP 3
`define SCSC_BIT_RST_WAKE  7
`define SCSC_SEL_DIV4      3'h0
`define SCSC_SEL_DIV2      3'h4
`define SCSC_FAST_HZ       28000000
`define SCSC_SLOW_HZ       32000
`define SCSC_MCLK_HZ       10000000
`define SCSC_POR_CYCLES    8
`define SCSC_RSTVEC        16'h0000
`endif

// ==== scsc_pkg.sv ====
// Types for the system clock and sleep controller
package scsc_pkg;
    typedef enum logic [1:0] {
        SCSC_RUN    = 2'b00,
        SCSC_SLEEP  = 2'b01,
        SCSC_WAKE   = 2'b10,
        SCSC_RESET  = 2'b11
    } scsc_state_e;
    typedef logic [7:0] scsc_byte_t;
endpackage : scsc_pkg

// ==== scsc_osc_if.sv ====
// Oscillator enable and tick carrier between controller and oscillator model
interface scsc_osc_if;
    logic fast_run;
    logic fast_tick;
    logic slow_tick;
    modport ctrl (output fast_run, input fast_tick, input slow_tick);
    modport osc  (input fast_run, output fast_tick, output slow_tick);
endinterface : scsc_osc_if

// ==== scsc_osc.sv ====
// Fast and slow RC oscillator tick generators derived from mclk
`include "scsc_map.svh"
module scsc_osc #(
    parameter int FAST_HZ = `SCSC_FAST_HZ,
    parameter int SLOW_HZ = `SCSC_SLOW_HZ,
    parameter int MCLK_HZ = `SCSC_MCLK_HZ
) (
    // Clock and reset
    input  wire logic  mclk,
    input  wire logic  reset,
    // Oscillator side
    scsc_osc_if.osc    osc
);
    // Fast rate lies above mclk, so each mclk while running is one tick;
    // the slow rate is a plain divider of mclk
    localparam int SLOW_DIV = MCLK_HZ / SLOW_HZ;
    if (SLOW_DIV < 2 || SLOW_DIV > 65536 ||
        FAST_HZ < MCLK_HZ) begin : g_bad_rate
        $error("scsc_osc: unsupported oscillator rates");
    end
    logic [15:0] slow_cnt;
    always_ff @(posedge mclk) begin
        if (reset) begin
            osc.fast_tick <= 1'b0;
        end else begin
            osc.fast_tick <= osc.fast_run;
        end
    end
    // Slow oscillator runs from power-up regardless of software
    always_ff @(posedge mclk) begin
        if (reset) begin
            slow_cnt      <= 16'h0;
            osc.slow_tick <= 1'b0;
        end else if (slow_cnt == 16'(SLOW_DIV - 1)) begin
            slow_cnt      <= 16'h0;
            osc.slow_tick <= 1'b1;
        end else begin
            slow_cnt      <= slow_cnt + 16'h1;
            osc.slow_tick <= 1'b0;
        end
    end
endmodule : scsc_osc

// ==== scsc_ctrl.sv ====
// System clock, sleep and reset controller top
`include "scsc_map.svh"
// Functional notes
// - Fast oscillator fixed, clocks flash directly and sources the core clock.
// - Slow oscillator fixed, clocks the watchdog.
// - Both oscillators run from power-up without software action.
// - Select code 000 gives fast/4, 100 gives fast/2, others reserved.
// - Core instruction enable is one per two core clock periods.
// - In sleep only slow oscillator (fast one if kept), watchdog and wake pins run; core halted.
// - Writing one to bit 2 of power control enters sleep.
// - Bit 3 keeps fast oscillator running in sleep; zero stops it.
// - Bit 1 lets watchdog overflow wake from sleep.
// - Bit 0 lets a wake pin event wake from sleep; resets to one.
// - Reset-on-wake zero resumes; one resets and fetches from zero.
// - Reset comes from power-on, watchdog overflow or reset-on-wake; no pin.
// - Power-on reset restores all registers, flash untouched.
// - Watchdog reset keeps RAM, registers and flash.
module scsc_ctrl
    import scsc_pkg::*;
#(
    parameter int POR_CYCLES = `SCSC_POR_CYCLES
) (
    // Clock and power-on reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // External data space register access
    input  wire logic [15:0]      xaddr,
    input  wire logic             xwr,
    input  wire logic             xrd,
    input  wire scsc_pkg::scsc_byte_t xwdata,
    output logic [7:0]            xrdata,
    // Wake and watchdog events
    input  wire logic             wake_pin_event,
    input  wire logic             wdt_overflow,
    // Clock enables
    output logic                  flash_clk_en,
    output logic                  core_clk_en,
    output logic                  instr_clk_en,
    output logic                  wdt_clk_en,
    output logic                  fast_osc_on,
    // Core control
    output logic                  core_halt,
    output logic                  core_reset,
    output logic                  por_reset,
    output logic [15:0]           pc_reset_vector
);
    import scsc_pkg::*;
    // Counter is eight bits wide, so longer reset sequences are refused
    if (POR_CYCLES < 1 || POR_CYCLES > 255) begin : g_bad_por
        $error("scsc_ctrl: POR_CYCLES out of range");
    end

    // Reset images, sliced per field below
    localparam scsc_byte_t PSC_RST = `SCSC_PSC_RESET;
    localparam scsc_byte_t CCS_RST = `SCSC_CCS_RESET;

    // ========================================
    // Helper functions
    // Register decode is shared by the write and read paths
    function automatic logic reg_hit(input logic [15:0] addr,
                                     input logic [15:0] base);
        return addr == base;
    endfunction : reg_hit

    // Only the half-rate code selects fast/2; reserved codes run at fast/4
    function automatic logic div_is_half(input logic [2:0] sel);
        return sel == `SCSC_SEL_DIV2;
    endfunction : div_is_half

    // Read image of power control; the sleep entry bit always reads zero
    function automatic scsc_byte_t psc_image(input logic rst_wake,
                                             input logic keep_fast,
                                             input logic wdt_wake,
                                             input logic pin_wake);
        scsc_byte_t img;
        img                      = 8'h00;
        img[`SCSC_BIT_RST_WAKE]  = rst_wake;
        img[`SCSC_BIT_FAST_KEEP] = keep_fast;
        img[`SCSC_BIT_WDT_WAKE]  = wdt_wake;
        img[`SCSC_BIT_PIN_WAKE]  = pin_wake;
        return img;
    endfunction : psc_image

    // ========================================
    // Oscillators
    scsc_osc_if osc_bus ();
    scsc_osc u_osc (
        .mclk  (mclk),
        .reset (reset),
        .osc   (osc_bus.osc)
    );

    // ========================================
    // Wake pin synchroniser, three stages
    logic [2:0]  pin_sync;
    logic        pin_level;
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_sync  <= 3'h0;
            pin_level <= 1'b0;
        end else begin
            pin_sync  <= {pin_sync[1:0], wake_pin_event};
            if (pin_sync[1] == pin_sync[2]) begin
                pin_level <= pin_sync[2];
            end
        end
    end
    logic pin_level_d;
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_level_d <= 1'b0;
        end else begin
            pin_level_d <= pin_level;
        end
    end
    logic pin_rise;
    assign pin_rise = pin_level & ~pin_level_d;

    // ========================================
    // Registers
    logic       wake_by_pin;
    logic       wake_by_watchdog;
    logic       fast_osc_keep_in_sleep;
    logic       reset_on_wake;
    logic [2:0] core_clk_div_sel;
    logic       sleep_req;
    logic       psc_hit;
    logic       ccs_hit;
    scsc_state_e state;
    logic [7:0] por_cnt;
    assign psc_hit = reg_hit(xaddr, `SCSC_PSC_ADDR);
    assign ccs_hit = reg_hit(xaddr, `SCSC_CCS_ADDR);

    // Power-on reset restores values; watchdog reset leaves them
    always_ff @(posedge mclk) begin
        if (reset) begin
            wake_by_pin            <= PSC_RST[`SCSC_BIT_PIN_WAKE];
            wake_by_watchdog       <= PSC_RST[`SCSC_BIT_WDT_WAKE];
            fast_osc_keep_in_sleep <= PSC_RST[`SCSC_BIT_FAST_KEEP];
            reset_on_wake          <= PSC_RST[`SCSC_BIT_RST_WAKE];
        end else if (xwr && psc_hit && state == SCSC_RUN) begin
            wake_by_pin            <= xwdata[`SCSC_BIT_PIN_WAKE];
            wake_by_watchdog       <= xwdata[`SCSC_BIT_WDT_WAKE];
            fast_osc_keep_in_sleep <= xwdata[`SCSC_BIT_FAST_KEEP];
            reset_on_wake          <= xwdata[`SCSC_BIT_RST_WAKE];
        end
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            core_clk_div_sel <= CCS_RST[2:0];
        end else if (xwr && ccs_hit && state == SCSC_RUN) begin
            core_clk_div_sel <= xwdata[2:0];
        end
    end
    // Sleep entry bit is write-only and never stored
    assign sleep_req = xwr && psc_hit && xwdata[`SCSC_BIT_SLEEP];

    always_ff @(posedge mclk) begin
        if (reset) begin
            xrdata <= 8'h00;
        end else if (xrd && psc_hit) begin
            xrdata <= psc_image(reset_on_wake, fast_osc_keep_in_sleep,
                                wake_by_watchdog, wake_by_pin);
        end else if (xrd && ccs_hit) begin
            xrdata <= {5'h00, core_clk_div_sel};
        end else begin
            xrdata <= 8'h00;
        end
    end

    // ========================================
    // Sleep and reset sequencing
    logic wake_ok;
    logic wdt_rst;
    // Overflow wakes only when enabled; pin event likewise
    assign wake_ok = (wdt_overflow && wake_by_watchdog) ||
                     (pin_rise && wake_by_pin);
    // Overflow in run state resets; reset-on-wake is the other non-power reset source
    assign wdt_rst = wdt_overflow && state == SCSC_RUN;

    // Watchdog reset wins over a sleep write in the same cycle
    scsc_state_e next_state;
    always_comb begin
        next_state = state;
        case (state)
            SCSC_RUN: begin
                if (wdt_rst) begin
                    next_state = SCSC_RESET;
                end else if (sleep_req) begin
                    next_state = SCSC_SLEEP;
                end
            end
            SCSC_SLEEP: begin
                if (wake_ok) begin
                    next_state = SCSC_WAKE;
                end
            end
            SCSC_WAKE: begin
                // Clock restarted one cycle before release
                next_state = reset_on_wake ? SCSC_RESET : SCSC_RUN;
            end
            SCSC_RESET: begin
                if (por_cnt == 8'h00) begin
                    next_state = SCSC_RUN;
                end
            end
            default: next_state = SCSC_RESET;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= SCSC_RESET;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            por_cnt <= 8'(POR_CYCLES - 1);
        end else if (state != SCSC_RESET) begin
            por_cnt <= 8'(POR_CYCLES - 1);
        end else if (por_cnt != 8'h00) begin
            por_cnt <= por_cnt - 8'h1;
        end
    end

    // ========================================
    // Clock generation
    logic       fast_run;
    logic [1:0] div_cnt;
    logic       core_tick;
    logic       instr_phase;
    // Fast oscillator always on, stopped in sleep unless kept
    assign fast_run = !(state == SCSC_SLEEP && !fast_osc_keep_in_sleep);
    assign osc_bus.fast_run = fast_run;

    always_ff @(posedge mclk) begin
        if (reset) begin
            div_cnt <= 2'h0;
        end else if (state == SCSC_SLEEP) begin
            div_cnt <= 2'h0;
        end else if (osc_bus.fast_tick) begin
            div_cnt <= div_cnt + 2'h1;
        end
    end
    // Reserved codes fall back to fast/4 so the core never loses its clock
    always_comb begin
        if (div_is_half(core_clk_div_sel)) begin
            core_tick = osc_bus.fast_tick && div_cnt[0];
        end else begin
            core_tick = osc_bus.fast_tick && div_cnt == 2'h3;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            instr_phase <= 1'b0;
        end else if (state != SCSC_RUN) begin
            instr_phase <= 1'b0;
        end else if (core_tick) begin
            instr_phase <= ~instr_phase;
        end
    end

    // ========================================
    // Outputs
    // Flash idles in sleep even when the fast oscillator is kept running
    always_ff @(posedge mclk) begin
        if (reset) begin
            flash_clk_en <= 1'b0;
            wdt_clk_en   <= 1'b0;
            fast_osc_on  <= 1'b1;
        end else begin
            flash_clk_en <= osc_bus.fast_tick &&
                            state != SCSC_SLEEP;
            wdt_clk_en   <= osc_bus.slow_tick;
            fast_osc_on  <= fast_run;
        end
    end
    // Core and instruction enables only while running
    always_ff @(posedge mclk) begin
        if (reset) begin
            core_clk_en  <= 1'b0;
            instr_clk_en <= 1'b0;
        end else begin
            core_clk_en  <= core_tick && state == SCSC_RUN;
            instr_clk_en <= core_tick && instr_phase &&
                            state == SCSC_RUN;
        end
    end
    // Power-on flag follows the reset input only, never the watchdog
    always_ff @(posedge mclk) begin
        if (reset) begin
            core_halt       <= 1'b1;
            core_reset      <= 1'b1;
            por_reset       <= 1'b1;
            pc_reset_vector <= `SCSC_RSTVEC;
        end else begin
            core_halt       <= state != SCSC_RUN;
            core_reset      <= state == SCSC_RESET;
            por_reset       <= 1'b0;
            pc_reset_vector <= `SCSC_RSTVEC;
        end
    end
endmodule : scsc_ctrl

// ==== scsc_ctrl_sva.sv ====
// Port checker for the clock, sleep and reset controller
module scsc_ctrl_sva
    import scsc_pkg::*;
#(
    parameter int POR_CYCLES = 8
) (
    // Clock and reset
    input wire logic                 mclk,
    input wire logic                 reset,
    // Register access
    input wire logic [15:0]          xaddr,
    input wire logic                 xwr,
    input wire logic                 xrd,
    input wire scsc_pkg::scsc_byte_t xwdata,
    input wire logic [7:0]           xrdata,
    // Events
    input wire logic                 wake_pin_event,
    input wire logic                 wdt_overflow,
    // Clock enables
    input wire logic                 flash_clk_en,
    input wire logic                 core_clk_en,
    input wire logic                 instr_clk_en,
    input wire logic                 wdt_clk_en,
    input wire logic                 fast_osc_on,
    // Core control
    input wire logic                 core_halt,
    input wire logic                 core_reset,
    input wire logic                 por_reset,
    input wire logic [15:0]          pc_reset_vector
);
    import scsc_pkg::*;
    // ==========
    // Reset length counter
    // Tolerance of one cycle covers the registered output stage
    localparam int LO = POR_CYCLES - 1;
    localparam int HI = POR_CYCLES + 1;
    logic [8:0] rst_len;
    always_ff @(posedge mclk) begin
        if (reset || !core_reset) begin
            rst_len <= 9'h000;
        end else begin
            rst_len <= rst_len + 9'h001;
        end
    end
    // ==========
    // Properties
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_sleep_wr;
        xwr && xaddr == 16'hF000 && xwdata[2] && !core_halt && !wdt_overflow;
    endsequence
    a_flash_osc: assert property (flash_clk_en |-> fast_osc_on)
        else $error("flash tick without fast oscillator");
    a_core_run: assert property (core_clk_en |-> !core_halt)
        else $error("core clock while halted");
    a_instr_half: assert property (instr_clk_en |-> core_clk_en)
        else $error("instruction tick off core clock");
    a_sleep_entry: assert property (s_sleep_wr |-> ##[1:3] core_halt)
        else $error("sleep write did not halt core");
    a_por_start: assert property ($fell(reset) |-> core_halt && core_reset)
        else $error("power-on reset not held after release");
    a_reset_len: assert property ($fell(core_reset) |->
        rst_len >= LO && rst_len <= HI)
        else $error("reset sequence length wrong");
    a_wdt_reset: assert property (
        wdt_overflow && !core_halt |-> ##[1:2] core_reset)
        else $error("watchdog overflow gave no reset");
    a_reset_vec: assert property (core_reset |-> pc_reset_vector == 16'h0000)
        else $error("reset vector not zero");
endmodule : scsc_ctrl_sva

bind scsc_ctrl scsc_ctrl_sva #(.POR_CYCLES(POR_CYCLES)) u_sva (
    .mclk(mclk), .reset(reset), .xaddr(xaddr), .xwr(xwr), .xrd(xrd),
    .xwdata(xwdata), .xrdata(xrdata), .wake_pin_event(wake_pin_event),
    .wdt_overflow(wdt_overflow), .flash_clk_en(flash_clk_en),
    .core_clk_en(core_clk_en), .instr_clk_en(instr_clk_en),
    .wdt_clk_en(wdt_clk_en), .fast_osc_on(fast_osc_on),
    .core_halt(core_halt), .core_reset(core_reset), .por_reset(por_reset),
    .pc_reset_vector(pc_reset_vector)
);

// ==== tb.sv ====
// Self-checking testbench for the clock, sleep and reset controller
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import scsc_pkg::*;
    // ==========
    // Signals
    localparam int POR = 4;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] xaddr, pc_reset_vector;
    logic xwr, xrd, wake_pin_event, wdt_overflow;
    scsc_byte_t xwdata;
    logic [7:0] xrdata;
    logic flash_clk_en, core_clk_en, instr_clk_en, wdt_clk_en, fast_osc_on;
    logic core_halt, core_reset, por_reset;
    int err_count = 0;
    int n_tests = 0;
    int c_core, c_instr, c_flash, c_wdt;
    always #50 mclk = ~mclk;
    scsc_ctrl #(.POR_CYCLES(POR)) u_dut (
        .mclk(mclk), .reset(reset),
        .xaddr(xaddr), .xwr(xwr), .xrd(xrd), .xwdata(xwdata), .xrdata(xrdata),
        .wake_pin_event(wake_pin_event), .wdt_overflow(wdt_overflow),
        .flash_clk_en(flash_clk_en), .core_clk_en(core_clk_en),
        .instr_clk_en(instr_clk_en), .wdt_clk_en(wdt_clk_en),
        .fast_osc_on(fast_osc_on), .core_halt(core_halt),
        .core_reset(core_reset), .por_reset(por_reset),
        .pc_reset_vector(pc_reset_vector)
    );
    // ==========
    // Tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        tick(1);
        xaddr = a;
        xwdata = d;
        xwr = 1'b1;
        tick(1);
        xwr = 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        tick(1);
        xaddr = a;
        xrd = 1'b1;
        tick(1);
        xrd = 1'b0;
        chk(xrdata, e);
    endtask : rd
    task automatic cnt(input int n);
        tick(4);
        {c_core, c_instr, c_flash, c_wdt} = '0;
        repeat (n) begin
            tick(1);
            c_core += core_clk_en;
            c_instr += instr_clk_en;
            c_flash += flash_clk_en;
            c_wdt += wdt_clk_en;
        end
    endtask : cnt
    task automatic wait_run();
        for (int i = 0; i < 100 && core_halt !== 1'b0; i++) tick(1);
        chk(core_halt, 0);
    endtask : wait_run
    task automatic pulse_wdt();
        tick(1);
        wdt_overflow = 1'b1;
        tick(1);
        wdt_overflow = 1'b0;
        tick(3);
    endtask : pulse_wdt
    task automatic pulse_pin();
        tick(1);
        wake_pin_event = 1'b1;
        tick(6);
        wake_pin_event = 1'b0;
        tick(4);
    endtask : pulse_pin
    task automatic test_done();
        if (err_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    // ==========
    // Sequence
    initial begin
        {xaddr, xwr, xrd, xwdata, wake_pin_event, wdt_overflow} = '0;
        tick(10);
        reset = 1'b0;
        chk(core_reset, 1);
        chk(por_reset, 1);
        wait_run();
        chk(por_reset, 0);
        rd(16'hF000, 8'h01);
        rd(16'hF009, 8'h00);
        rd(16'hF004, 8'h00);
        cnt(40);
        chk(c_core, 10);
        chk(c_instr, 5);
        chk(c_flash, 40);
        wr(16'hF009, 8'h04);
        rd(16'hF009, 8'h04);
        cnt(40);
        chk(c_core, 20);
        chk(c_instr, 10);
        wr(16'hF009, 8'h01);
        cnt(624);
        chk(c_core, 156);
        chk(c_wdt, 2);
        // Sleep with fast oscillator off, watchdog wake only
        wr(16'hF000, 8'h06);
        tick(3);
        chk(core_halt, 1);
        chk(fast_osc_on, 0);
        cnt(20);
        chk(c_core + c_flash, 0);
        pulse_pin();
        chk(core_halt, 1);
        pulse_wdt();
        wait_run();
        chk(core_reset, 0);
        rd(16'hF000, 8'h02);
        rd(16'hF009, 8'h01);
        // Sleep keeping fast oscillator, pin wake only
        wr(16'hF000, 8'h0D);
        tick(3);
        chk(fast_osc_on, 1);
        cnt(8);
        chk(c_core + c_flash, 0);
        pulse_wdt();
        chk(core_halt, 1);
        pulse_pin();
        wait_run();
        // Reset on wake
        wr(16'hF000, 8'h85);
        pulse_pin();
        for (int i = 0; i < 20 && core_reset !== 1'b1; i++) tick(1);
        chk(core_reset, 1);
        chk(pc_reset_vector, 16'h0000);
        wait_run();
        // Watchdog reset in run keeps registers
        wr(16'hF009, 8'h04);
        pulse_wdt();
        chk(core_halt, 1);
        chk(por_reset, 0);
        wait_run();
        rd(16'hF009, 8'h04);
        // Second power-on reset restores registers
        tick(1);
        reset = 1'b1;
        tick(3);
        chk(por_reset, 1);
        chk(core_reset, 1);
        reset = 1'b0;
        wait_run();
        rd(16'hF009, 8'h00);
        rd(16'hF000, 8'h01);
        test_done();
    end
    initial begin
        #2000000;
        err_count++;
        test_done();
    end
endmodule : tb
